// ==== verilog/serdes_tx_pkg.sv ====
package serdes_tx_pkg;

  // -------------------------------------------------------------------------
  // configuration pin positions in the synchronised config vector
  // -------------------------------------------------------------------------
  localparam int unsigned CFG_WIDTH = 5;
  localparam int unsigned CFG_CODED = 0;
  localparam int unsigned CFG_ETH   = 1;
  localparam int unsigned CFG_LOOP  = 2;
  localparam int unsigned CFG_OFF   = 3;
  localparam int unsigned CFG_KEEP  = 4;

  // -------------------------------------------------------------------------
  // transmit word layout: {special, error, valid, data}
  // -------------------------------------------------------------------------
  localparam int unsigned WORD_WIDTH = 11;
  localparam int unsigned W_SPECIAL  = 10;
  localparam int unsigned W_ERROR    = 9;
  localparam int unsigned W_VALID    = 8;
  localparam int unsigned FIFO_DEPTH = 4;

  // -------------------------------------------------------------------------
  // code groups and serializer
  // -------------------------------------------------------------------------
  localparam int unsigned GROUP_WIDTH   = 10;
  localparam logic [7:0]  IDLE_COMMA    = 8'hBC;
  localparam logic [7:0]  ERROR_PROP    = 8'hFE;
  localparam logic [9:0]  INVALID_GROUP = 10'h3E0;
  localparam logic [3:0]  BIT_LAST      = 4'h9;
  localparam logic [3:0]  BIT_FIRST     = 4'h0;
  localparam logic [9:0]  GROUP_RESET   = 10'h000;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

endpackage

// ==== verilog/word_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // drain side
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PTR_W-1:0] writePtr;
  logic [PTR_W-1:0] readPtr;
  logic [CNT_W-1:0] count;
  logic             doPush;
  logic             doPop;

  assign inReady  = (count != FULL_COUNT);
  assign outValid = (count != '0);
  assign outData  = store[readPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (doPush)
    begin
      store[writePtr] <= inData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      writePtr <= '0;
      readPtr  <= '0;
    end
    else
    begin
      if (doPush)
      begin
        writePtr <= (writePtr == LAST_PTR) ? '0 : writePtr + 1'b1;
      end
      if (doPop)
      begin
        readPtr <= (readPtr == LAST_PTR) ? '0 : readPtr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      count <= '0;
    end
    else if (doPush && !doPop)
    begin
      count <= count + 1'b1;
    end
    else if (doPop && !doPush)
    begin
      count <= count - 1'b1;
    end
  end

endmodule

`default_nettype wire

// ==== verilog/group_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module group_encoder (
  // byte in
  input  wire logic [7:0] byteIn,
  input  wire logic       isSpecial,
  input  wire logic       rdIn,
  // code group out, bit 0 goes on the line first
  output logic [9:0]      groupOut,
  output logic            rdOut
);

  // 5b/6b table, abcdei with a in the msb, for negative disparity
  localparam logic [5:0] SIX_CODE [0:31] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  // 3b/4b table, fghj with f in the msb, for negative disparity
  localparam logic [3:0] FOUR_CODE [0:7] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [5:0] SIX_K28   = 6'h0F;
  localparam logic [5:0] SIX_D7    = 6'h38;
  localparam logic [3:0] FOUR_ALT  = 4'h7;
  localparam logic [3:0] FOUR_Y3   = 4'hC;
  localparam logic [4:0] X_K28     = 5'h1C;
  localparam logic [2:0] Y_SEVEN   = 3'h7;

  logic [4:0] lowPart;
  logic [2:0] highPart;
  logic [5:0] six;
  logic [3:0] four;
  logic       rdMid;
  logic       useAlt;
  logic [9:0] msbFirst;
  logic       isK28;

  assign lowPart  = byteIn[4:0];
  assign highPart = byteIn[7:5];
  assign isK28    = isSpecial && (lowPart == X_K28);

  always_comb
  begin
    six = (isSpecial && lowPart == X_K28) ? SIX_K28 : SIX_CODE[lowPart];
    if (rdIn && (($countones(six) != 3) || six == SIX_D7))
    begin
      six = ~six;
    end
    rdMid = ($countones(six) != 3) ? ~rdIn : rdIn;
    // alternate x.7 keeps run lengths at four outside commas
    useAlt = (highPart == Y_SEVEN) &&
             (isSpecial ||
              (!rdMid && (lowPart == 5'h11 || lowPart == 5'h12 || lowPart == 5'h14)) ||
              (rdMid && (lowPart == 5'h0B || lowPart == 5'h0D || lowPart == 5'h0E)));
    four = useAlt ? FOUR_ALT : FOUR_CODE[highPart];
    if (rdMid && (($countones(four) != 2) || four == FOUR_Y3))
    begin
      four = ~four;
    end
    // after a positive-start k28 block the balanced tails other than x.3 are complemented
    if (isK28 && !rdMid && ($countones(four) == 2) && (four != FOUR_Y3))
    begin
      four = ~four;
    end
    rdOut    = ($countones(four) != 2) ? ~rdMid : rdMid;
    msbFirst = {six, four};
    for (int i = 0; i < 10; i++)
    begin
      groupOut[i] = msbFirst[9 - i];
    end
  end

endmodule

`default_nettype wire

// ==== verilog/serdes_tx_input_port.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R01: each word becomes a code group unless pre-encoded, then shifts out serially.
// R02: parallel inputs are captured on the channel's own transmit clock.
// R03: partner drives an eight-bit data byte per word.
// R04: coded input: special flag enables receiver comma realignment, not encoded.
// R05: backplane uncoded: special flag makes the byte a special code group.
// R06: coded input: error pin is code-group bit 9.
// R07: backplane uncoded: error pin forces an invalid code group.
// R08: Ethernet uncoded: error pin acts as GMII transmit error.
// R09: coded input: data-valid pin is code-group bit 8.
// R10: uncoded: only words with data-valid high are taken and sent.
// R11: loopback enable routes the transmitted stream back to the receiver.
// R12: disable input turns the transmitter off.
// R13: Ethernet mode uses 8B/10B transmit coding of 1000BASE-X.
// R14: coded input bypasses the internal encoder.
// R15: compliance select chooses Ethernet modes, otherwise backplane mode.
// R16: double-rate capture splits the word over both clock edges; the code captures the whole word on the rising edge only.
// R17: during loopback link outputs stay on only if output-keep is high.
// R18: encoder tracks running disparity across consecutive code groups.
module serdes_tx_input_port (
  // core clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // parallel transmit port, chan_tx_clock domain
  input  wire logic       chan_tx_clock,
  input  wire logic [7:0] tx_data_byte,
  input  wire logic       tx_special_flag,
  input  wire logic       tx_error_bit,
  input  wire logic       tx_data_valid,
  output logic            txReady,
  // configuration pins
  input  wire logic       coded_input_select,
  input  wire logic       ethernet_compliance_select,
  input  wire logic       chan_loopback_enable,
  input  wire logic       chan_tx_off,
  input  wire logic       loopback_output_keep,
  // link and receiver-facing outputs
  output logic            linkP,
  output logic            linkN,
  output logic            linkOutEnable,
  output logic            loopbackData,
  output logic            commaRealignEnable
);

  // -------------------------------------------------------------------------
  // transmit clock domain
  // -------------------------------------------------------------------------
  logic [1:0]                             txRstPipe;
  logic                                   txRun;
  logic                                   txCodedMeta;
  logic                                   txCoded;
  logic [serdes_tx_pkg::WORD_WIDTH-1:0]   holdWord;
  logic                                   reqToggle;
  logic                                   ackMeta;
  logic                                   ackSync;
  logic                                   ackToggle;
  logic                                   capture;

  assign txRun   = txRstPipe[1];
  // coded mode takes a code group whenever ready, uncoded only when also valid
  assign capture = txReady && (txCoded || tx_data_valid); // [R10] [R02]

  always_ff @(posedge chan_tx_clock)
  begin
    txRstPipe <= {txRstPipe[0], rst_b};
  end

  always_ff @(posedge chan_tx_clock)
  begin
    if (!txRun)
    begin
      txCodedMeta <= 1'b0;
      txCoded     <= 1'b0;
      ackMeta     <= 1'b0;
      ackSync     <= 1'b0;
    end
    else
    begin
      txCodedMeta <= coded_input_select;
      txCoded     <= txCodedMeta;
      ackMeta     <= ackToggle;
      ackSync     <= ackMeta;
    end
  end

  // single-edge capture only; the word is held until the core acknowledges
  always_ff @(posedge chan_tx_clock)
  begin
    if (!txRun)
    begin
      holdWord  <= '0;
      reqToggle <= 1'b0;
    end
    else if (capture)
    begin
      holdWord  <= {tx_special_flag, tx_error_bit, tx_data_valid, tx_data_byte}; // [R03] [R16]
      reqToggle <= ~reqToggle;
    end
  end

  always_ff @(posedge chan_tx_clock)
  begin
    if (!txRun)
    begin
      txReady <= 1'b0;
    end
    else if (capture)
    begin
      txReady <= 1'b0;
    end
    else if (ackSync == reqToggle)
    begin
      txReady <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // core domain: crossing and configuration
  // -------------------------------------------------------------------------
  logic [serdes_tx_pkg::CFG_WIDTH-1:0] cfgMeta;
  logic [serdes_tx_pkg::CFG_WIDTH-1:0] cfg;
  logic                                reqMeta;
  logic                                reqSync;
  logic                                fifoInReady;
  logic                                pushValid;

  assign pushValid = (reqSync != ackToggle);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cfgMeta <= '0;
      cfg     <= '0;
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
    end
    else
    begin
      cfgMeta <= {loopback_output_keep, chan_tx_off, chan_loopback_enable,
                  ethernet_compliance_select, coded_input_select};
      cfg     <= cfgMeta;
      reqMeta <= reqToggle;
      reqSync <= reqMeta;
    end
  end

  // a full fifo withholds the acknowledge, which stalls the partner side
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ackToggle <= 1'b0;
    end
    else if (pushValid && fifoInReady)
    begin
      ackToggle <= reqSync;
    end
  end

  // -------------------------------------------------------------------------
  // word buffer
  // -------------------------------------------------------------------------
  logic [serdes_tx_pkg::WORD_WIDTH-1:0] headWord;
  logic                                 headValid;
  logic                                 load;
  logic                                 pop;

  word_fifo #(
    .WIDTH (serdes_tx_pkg::WORD_WIDTH),
    .DEPTH (serdes_tx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .rst_b    (rst_b),
    .inData   (holdWord),
    .inValid  (pushValid),
    .inReady  (fifoInReady),
    .outData  (headWord),
    .outValid (headValid),
    .outReady (pop)
  );

  // -------------------------------------------------------------------------
  // code group selection
  // -------------------------------------------------------------------------
  logic [7:0] encByte;
  logic       encSpecial;
  logic       useEncoder;
  logic [9:0] encGroup;
  logic       encRd;
  logic [9:0] nextGroup;
  logic       nextRealign;
  logic       rd;
  logic       coded;
  logic       ethernet;

  assign coded    = cfg[serdes_tx_pkg::CFG_CODED];
  assign ethernet = cfg[serdes_tx_pkg::CFG_ETH];

  group_encoder u_encoder (
    .byteIn    (encByte),
    .isSpecial (encSpecial),
    .rdIn      (rd),
    .groupOut  (encGroup),
    .rdOut     (encRd)
  );

  always_comb
  begin
    encByte     = serdes_tx_pkg::IDLE_COMMA;
    encSpecial  = 1'b1;
    useEncoder  = 1'b1;
    nextRealign = 1'b0;
    if (!headValid)
    begin
      // an empty buffer sends commas so the far receiver keeps lock
      useEncoder = 1'b1;
    end
    else if (coded)
    begin
      useEncoder  = 1'b0; // [R14]
      nextRealign = headWord[serdes_tx_pkg::W_SPECIAL]; // [R04]
    end
    else if (ethernet)
    begin
      // [R15] [R13]
      if (headWord[serdes_tx_pkg::W_ERROR])
      begin
        encByte = serdes_tx_pkg::ERROR_PROP; // [R08]
      end
      else
      begin
        encByte    = headWord[7:0];
        encSpecial = 1'b0;
      end
    end
    else if (headWord[serdes_tx_pkg::W_ERROR])
    begin
      useEncoder = 1'b0; // [R07]
    end
    else
    begin
      encByte    = headWord[7:0];
      encSpecial = headWord[serdes_tx_pkg::W_SPECIAL]; // [R05]
    end
    if (useEncoder)
    begin
      nextGroup = encGroup; // [R01]
    end
    else if (coded && headValid)
    begin
      nextGroup = headWord[serdes_tx_pkg::W_ERROR:0]; // [R06] [R09]
    end
    else
    begin
      nextGroup = serdes_tx_pkg::INVALID_GROUP;
    end
  end

  // -------------------------------------------------------------------------
  // serializer
  // -------------------------------------------------------------------------
  logic [9:0] shiftReg;
  logic [3:0] bitCount;

  assign load = (bitCount == serdes_tx_pkg::BIT_LAST);
  assign pop  = load && headValid;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      bitCount <= serdes_tx_pkg::BIT_LAST;
      shiftReg <= serdes_tx_pkg::GROUP_RESET;
    end
    else if (load)
    begin
      bitCount <= serdes_tx_pkg::BIT_FIRST;
      shiftReg <= nextGroup; // [R01]
    end
    else
    begin
      bitCount <= bitCount + 4'h1;
      shiftReg <= {1'b0, shiftReg[9:1]};
    end
  end

  // pre-encoded groups leave the disparity to the partner
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rd <= 1'b0;
    end
    else if (load && useEncoder)
    begin
      rd <= encRd; // [R18]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      commaRealignEnable <= 1'b0;
    end
    else if (load)
    begin
      commaRealignEnable <= nextRealign; // [R04]
    end
  end

  // -------------------------------------------------------------------------
  // link drivers and loopback
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      linkP         <= 1'b0;
      linkN         <= 1'b1;
      linkOutEnable <= 1'b0;
      loopbackData  <= 1'b0;
    end
    else
    begin
      linkP         <= shiftReg[0];
      linkN         <= ~shiftReg[0];
      linkOutEnable <= !cfg[serdes_tx_pkg::CFG_OFF] && // [R12]
                       !(cfg[serdes_tx_pkg::CFG_LOOP] && !cfg[serdes_tx_pkg::CFG_KEEP]); // [R17]
      loopbackData  <= cfg[serdes_tx_pkg::CFG_LOOP] && shiftReg[0]; // [R11]
    end
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_group_period;
    load |=> (!load)[*8] ##1 !load ##1 load;
  endproperty
  a_group_period: assert property (p_group_period) else $error("group period wrong"); // [R01]

  property p_tx_off;
    cfg[serdes_tx_pkg::CFG_OFF] |=> !linkOutEnable;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("link driven while disabled"); // [R12]

  property p_loop_keep;
    (cfg[serdes_tx_pkg::CFG_LOOP] && !cfg[serdes_tx_pkg::CFG_OFF])
      |=> (linkOutEnable == $past(cfg[serdes_tx_pkg::CFG_KEEP]));
  endproperty
  a_loop_keep: assert property (p_loop_keep) else $error("loopback output enable wrong"); // [R17]

  property p_loop_data;
    cfg[serdes_tx_pkg::CFG_LOOP] ##1 cfg[serdes_tx_pkg::CFG_LOOP] |-> loopbackData == linkP;
  endproperty
  a_loop_data: assert property (p_loop_data) else $error("loopback differs from link"); // [R11]

  property p_coded_pass;
    (load && headValid && coded)
      |=> shiftReg == $past(headWord[serdes_tx_pkg::W_ERROR:0]) ##1 linkP == $past(shiftReg[0]);
  endproperty
  a_coded_pass: assert property (p_coded_pass) else $error("coded group altered"); // [R14]

  property p_realign;
    (load && headValid && coded)
      |=> commaRealignEnable == $past(headWord[serdes_tx_pkg::W_SPECIAL]);
  endproperty
  a_realign: assert property (p_realign) else $error("realign flag not passed"); // [R04]

  property p_force_error;
    (load && headValid && !coded && !ethernet && headWord[serdes_tx_pkg::W_ERROR])
      |=> shiftReg == serdes_tx_pkg::INVALID_GROUP && rd == $past(rd);
  endproperty
  a_force_error: assert property (p_force_error) else $error("forced error not sent"); // [R07]

  property p_gmii_error;
    (headValid && !coded && ethernet && headWord[serdes_tx_pkg::W_ERROR])
      |-> encSpecial && encByte == serdes_tx_pkg::ERROR_PROP;
  endproperty
  a_gmii_error: assert property (p_gmii_error) else $error("error not propagated"); // [R08]

  property p_special;
    (headValid && !coded && !ethernet && !headWord[serdes_tx_pkg::W_ERROR])
      |-> encSpecial == headWord[serdes_tx_pkg::W_SPECIAL];
  endproperty
  a_special: assert property (p_special) else $error("special flag not encoded"); // [R05]

  property p_disparity;
    (load && useEncoder) |->
      (rd ? ($countones(nextGroup) inside {4, 5}) : ($countones(nextGroup) inside {5, 6}));
  endproperty
  a_disparity: assert property (p_disparity) else $error("disparity out of balance"); // [R18]

  property p_valid_gate;
    @(posedge chan_tx_clock) disable iff (!txRun)
      (txReady && !txCoded && !tx_data_valid) |=> txReady && $stable(reqToggle);
  endproperty
  a_valid_gate: assert property (p_valid_gate) else $error("word taken without valid"); // [R10]

  c_coded:   cover property (load && headValid && coded);
  c_eth_err: cover property (load && headValid && ethernet && !coded &&
                             headWord[serdes_tx_pkg::W_ERROR]);
  c_loop:    cover property (cfg[serdes_tx_pkg::CFG_LOOP] && linkOutEnable);
  c_full:    cover property (pushValid && !fifoInReady);

endmodule

`default_nettype wire

// ==== verilog/serdes_tx_input_port_unused_placeholder_none.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/mac_tx_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module mac_tx_model (
  // parallel port, launched on the channel clock
  input  wire logic txClk,
  input  wire logic txReady,
  input  wire logic coded,
  output logic [7:0] txByte,
  output logic       txSpecial,
  output logic       txError,
  output logic       txValid
);
  logic busy;

  initial
  begin
    busy = 1'b0;
    {txSpecial, txError, txValid, txByte} = 11'h000;
  end

  // between words: idle comma in coded mode, else valid low with data inverted each edge
  always @(posedge txClk)
  begin
    if (!busy)
    begin
      if (coded)
        {txError, txValid, txByte} <= 10'h17C;
      else
      begin
        txValid <= 1'b0;
        txByte  <= ~txByte;
        txError <= ~txError;
      end
    end
  end

  // hold = 0: keep the word until taken; hold > 0: keep it that many edges
  task automatic send(input logic [10:0] w, input int hold);
    int n;
    n    = 0;
    busy = 1'b1;
    @(posedge txClk);
    {txSpecial, txError, txValid, txByte} <= w;
    if (hold > 0)
      repeat (hold) @(posedge txClk);
    else
    begin
      do
      begin
        @(posedge txClk);
        n++;
      end
      while (txReady !== 1'b1 && n < 300);
    end
    busy = 1'b0;
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_serdes_tx_input_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_serdes_tx_input_port;
  logic       core_clk, rst_b, txClk, coded, eth, loop, off, keep;
  logic       txReady, linkP, linkN, linkOutEnable, loopbackData, commaRealignEnable;
  logic [7:0] txByte;
  logic       txSpecial, txError, txValid, locked;
  logic [9:0] sh, g;
  logic [3:0] cnt;
  logic [9:0] gotQ[$];
  logic [9:0] sentQ[$];
  int         mismatches, compares, seed, i;

  initial
  begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end

  // channel clock at an unrelated phase
  initial
  begin
    txClk = 0;
    #7;
    forever #32 txClk = ~txClk;
  end

  serdes_tx_input_port DUT (
    .core_clk(core_clk), .rst_b(rst_b), .chan_tx_clock(txClk), .tx_data_byte(txByte),
    .tx_special_flag(txSpecial), .tx_error_bit(txError), .tx_data_valid(txValid),
    .txReady(txReady), .coded_input_select(coded), .ethernet_compliance_select(eth),
    .chan_loopback_enable(loop), .chan_tx_off(off), .loopback_output_keep(keep),
    .linkP(linkP), .linkN(linkN), .linkOutEnable(linkOutEnable),
    .loopbackData(loopbackData), .commaRealignEnable(commaRealignEnable));

  mac_tx_model mac (
    .txClk(txClk), .txReady(txReady), .coded(coded), .txByte(txByte),
    .txSpecial(txSpecial), .txError(txError), .txValid(txValid));

  function automatic logic isIdle(input logic [9:0] x);
    return x === 10'h17C || x === 10'h283;
  endfunction

  function automatic logic isK307(input logic [9:0] x);
    return x === 10'h05E || x === 10'h3A1;
  endfunction

  task automatic conclude();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chkGroup(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t group %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------------------
  // deserializer: locks once on the idle comma, then cuts every ten bits
  // ---------------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      locked = 1'b0;
      cnt    = 4'h0;
    end
    else
    begin
      chkBit(linkN, ~linkP);
      sh = {linkP, sh[9:1]};
      if (!locked && isIdle(sh))
      begin
        locked = 1'b1;
        cnt    = 4'h0;
      end
      else if (locked)
      begin
        cnt = cnt + 4'h1;
        if (cnt == 4'hA)
        begin
          cnt = 4'h0;
          if (!isIdle(sh))
            gotQ.push_back(sh);
        end
      end
    end
  end

  task automatic pop(output logic [9:0] x);
    int n;
    n = 0;
    while (gotQ.size() == 0 && n < 800)
    begin
      @(posedge core_clk);
      n++;
    end
    x = 10'h000;
    if (gotQ.size() == 0)
      chkBit(1'b0, 1'b1);
    else
      x = gotQ.pop_front();
  endtask

  // config pins pass two synchronisers; settle, then drop groups from the switch
  task automatic setMode(input logic c, input logic e, input logic l, input logic o,
                         input logic k);
    @(posedge core_clk);
    {coded, eth, loop, off, keep} <= {c, e, l, o, k};
    repeat (120) @(posedge core_clk);
    gotQ.delete();
  endtask

  task automatic chkLoop(input logic l);
    int a, b, z;
    logic p;
    a = 0;
    b = 0;
    z = 0;
    p = linkP;
    repeat (30)
    begin
      @(posedge core_clk);
      a += (loopbackData === linkP);
      b += (loopbackData === p);
      z += (loopbackData === 1'b0);
      p = linkP;
    end
    chkBit(l ? (a == 30 || b == 30) : (z == 30), 1'b1);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    mismatches = 0;
    compares   = 0;
    seed       = 32'hc856;
    {coded, eth, loop, off, keep} = 5'h00;
    rst_b = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (60) @(posedge core_clk);
    chkBit(linkOutEnable, 1'b1);
    setMode(1, 0, 0, 0, 0);
    for (i = 0; i < 8; i++)
    begin
      g = $random(seed);
      if (isIdle(g) || isK307(g))
        g = g ^ 10'h001;
      sentQ.push_back(g);
      mac.send({1'b0, g}, 0);
    end
    for (i = 0; i < 8; i++)
    begin
      pop(g);
      chkGroup(g, sentQ.pop_front());
    end
    mac.send(11'h555, 0);
    pop(g);
    chkGroup(g, 10'h155);
    chkBit(commaRealignEnable, 1'b1);
    mac.send(11'h0AA, 0);
    pop(g);
    chkGroup(g, 10'h0AA);
    chkBit(commaRealignEnable, 1'b0);
    setMode(0, 0, 0, 0, 0);
    mac.send({3'b010, 8'h00}, 8);
    repeat (120) @(posedge core_clk);
    chkBit(gotQ.size() == 0, 1'b1);
    mac.send({3'b011, 8'h00}, 0);
    pop(g);
    chkGroup(g, 10'h3E0);
    mac.send({3'b101, 8'hFE}, 0);
    pop(g);
    chkBit(isK307(g), 1'b1);
    mac.send({3'b001, 8'hFE}, 0);
    pop(g);
    chkBit(isK307(g), 1'b0);
    setMode(0, 1, 0, 0, 0);
    for (i = 0; i < 3; i++)
    begin
      mac.send({3'b011, 8'($random(seed))}, 0);
      pop(g);
      chkBit(isK307(g), 1'b1);
    end
    mac.send({3'b101, 8'hFE}, 0);
    pop(g);
    chkBit(isK307(g), 1'b0);
    for (i = 0; i < 5; i++)
    begin
      setMode(0, 0, i < 2, i == 4, i[0]);
      chkBit(linkOutEnable, !(i == 4) && !(i < 2 && !i[0]));
      chkLoop(i < 2);
    end
    conclude();
  end

  initial
  begin
    #3000000;
    mismatches++;
    conclude();
  end
endmodule

`default_nettype wire
